// >>> tmr_top.sv
// Sixteen-bit gated timer/counter with period match and gate-fall interrupt
//
// Operation
// - One 16-bit counter runs as timer or synchronous counter; sync select gives no asynchronous counting.
// - The counter serves as a real-time clock base or a free-running interval timer.
// - The interrupt flag sets on period match, or on a falling gate edge in gated mode.
// - Setting the run bit starts counting and clearing it stops counting.
// - A two-bit prescale select divides the count clock by 1, 8, 64 or 256.
// - Clock source select picks instruction or external clock; gate enable selects gated mode with the instruction clock only.
// - With external clock, both sync select settings count the same synchronised edge.
// - Counting continues in idle unless idle stop is set, and in sleep when the selected source stays active.
// - In gated mode the external gate input qualifies counting with any prescale.
`timescale 1ns/100ps
module tmr_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // External clock and gate pin, low-power RC tick
    input wire logic EXT_CLK_PIN,
    input wire logic LOW_POWER_RC_CLOCK_CLK,
    // Power state
    input wire logic CPU_IDLE,
    input wire logic CPU_SLEEP,
    // Interrupt request to the controller
    output logic IRQ,
    output logic [2:0] IRQ_PRIORITY
);
    tmr_pkg::ctrl_type ctrl_q;
    logic [15:0] count_q;
    logic [15:0] period_value_reg_q;
    logic irq_flag_q;
    logic timer_irq_enable_q;
    logic [2:0] timer_irq_priority_q;
    logic match_pend_q;
    logic ext_src;
    logic ext_sync;
    logic ext_prev_q;
    logic ext_rise;
    logic gate_prev_q;
    logic gate_fall;
    logic src_tick;
    logic stalled;
    logic ps_pulse;
    logic match_hit;
    logic flag_set;

    // ------------------------------------------------------------
    // External source selection and crossing
    // ------------------------------------------------------------
    // extended clock select
    assign ext_src = (ctrl_q.ecs == tmr_pkg::ECS_LOW_POWER_RC_CLOCK) ? LOW_POWER_RC_CLOCK_CLK : EXT_CLK_PIN;

    // Pin is asynchronous to CLK, so always synchronised before edge detect
    tmr_sync u_sync (
        .clk(CLK),
        .resetn(RESETN),
        .d(ext_src),
        .q(ext_sync)
    );

    // Edge history of the synchronised source
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ext_prev_q <= 1'b0;
            gate_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_sync;
            gate_prev_q <= ext_sync;
        end
    end

    assign ext_rise = ext_sync && !ext_prev_q;
    assign gate_fall = !ext_sync && gate_prev_q;

    // ------------------------------------------------------------
    // Count tick generation
    // ------------------------------------------------------------
    // idle stop halts counting in idle; otherwise keeps running
    // Sleep stops the instruction clock, so only external counting survives
    assign stalled = (CPU_IDLE && ctrl_q.idle_stop) || (CPU_SLEEP && !ctrl_q.cs);

    // source and gate; sync mode; gated timing
    // Both sync settings count the same synchronised edge here: one clock only
    always_comb begin
        src_tick = 1'b0;
        if (ctrl_q.run && !stalled) begin
            if (ctrl_q.cs) begin
                src_tick = ext_rise;
            end else if (ctrl_q.gate) begin
                src_tick = ext_sync;
            end else begin
                src_tick = 1'b1;
            end
        end
    end

    tmr_prescale u_ps (
        .clk(CLK),
        .resetn(RESETN),
        .clear(!ctrl_q.run),
        .sel(ctrl_q.ps),
        .tick(src_tick),
        .pulse(ps_pulse)
    );

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Match is only judged on a count pulse, so a stopped timer never wraps
    assign match_hit = ps_pulse && (count_q == period_value_reg_q);

    // A software write to the count wins over a pending pulse
    // sixteen-bit count; wrap to zero on the count after match; free-running
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            count_q <= 16'h0000;
        end else if (WR && ADDR == tmr_pkg::COUNT_OFF) begin
            count_q <= WDATA;
        end else if (ps_pulse) begin
            count_q <= match_hit ? 16'h0000 : count_q + 16'h0001;
        end
    end

    // Match flag stays pending one cycle so flag sets one cycle after the wrap
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            match_pend_q <= 1'b0;
        end else begin
            match_pend_q <= match_hit;
        end
    end

    // Gate fall is ignored with the external clock, where the pin is a clock
    // flag sources: period match, or gate fall in gated timer mode
    assign flag_set = match_pend_q || (ctrl_q.run && ctrl_q.gate && !ctrl_q.cs && gate_fall);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // run bit and mode fields written by software
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= tmr_pkg::ctrl_type'(9'h000);
        end else if (WR && ADDR == tmr_pkg::CTRL_OFF) begin
            ctrl_q.run <= WDATA[tmr_pkg::RUN_POS];
            ctrl_q.idle_stop <= WDATA[tmr_pkg::IDLE_STOP_POS];
            ctrl_q.ecs <= WDATA[tmr_pkg::ECS_LO +: 2];
            ctrl_q.gate <= WDATA[tmr_pkg::GATE_POS];
            ctrl_q.ps <= WDATA[tmr_pkg::PS_LO +: 2];
            ctrl_q.sync <= WDATA[tmr_pkg::SYNC_POS];
            ctrl_q.cs <= WDATA[tmr_pkg::CS_POS];
        end
    end

    // Period register loaded by software
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            period_value_reg_q <= tmr_pkg::PERIOD_RST;
        end else if (WR && ADDR == tmr_pkg::PERIOD_OFF) begin
            period_value_reg_q <= WDATA;
        end
    end

    // Interrupt flag: a set in the clearing cycle wins
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_flag_q <= 1'b0;
            timer_irq_enable_q <= 1'b0;
            timer_irq_priority_q <= tmr_pkg::PRI_RST;
        end else begin
            if (flag_set) begin
                irq_flag_q <= 1'b1;
            end else if (WR && ADDR == tmr_pkg::IRQ_OFF && !WDATA[tmr_pkg::IRQ_FLAG_POS]) begin
                irq_flag_q <= 1'b0;
            end
            if (WR && ADDR == tmr_pkg::IRQ_OFF) begin
                timer_irq_enable_q <= WDATA[tmr_pkg::IRQ_EN_POS];
                timer_irq_priority_q <= WDATA[tmr_pkg::IRQ_PRI_LO +: 3];
            end
        end
    end

    // Request and priority outputs
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            IRQ <= 1'b0;
            IRQ_PRIORITY <= tmr_pkg::PRI_RST;
        end else begin
            IRQ <= irq_flag_q && timer_irq_enable_q;
            IRQ_PRIORITY <= timer_irq_priority_q;
        end
    end

    // Sync select reads back but changes nothing: both settings use the synchronised edge
    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            RDATA <= 16'h0000;
            unique case (ADDR)
                tmr_pkg::CTRL_OFF: begin
                    RDATA[tmr_pkg::RUN_POS] <= ctrl_q.run;
                    RDATA[tmr_pkg::IDLE_STOP_POS] <= ctrl_q.idle_stop;
                    RDATA[tmr_pkg::ECS_LO +: 2] <= ctrl_q.ecs;
                    RDATA[tmr_pkg::GATE_POS] <= ctrl_q.gate;
                    RDATA[tmr_pkg::PS_LO +: 2] <= ctrl_q.ps;
                    RDATA[tmr_pkg::SYNC_POS] <= ctrl_q.sync;
                    RDATA[tmr_pkg::CS_POS] <= ctrl_q.cs;
                end
                tmr_pkg::COUNT_OFF: RDATA <= count_q;
                tmr_pkg::PERIOD_OFF: RDATA <= period_value_reg_q;
                tmr_pkg::IRQ_OFF: begin
                    RDATA[tmr_pkg::IRQ_FLAG_POS] <= irq_flag_q;
                    RDATA[tmr_pkg::IRQ_EN_POS] <= timer_irq_enable_q;
                    RDATA[tmr_pkg::IRQ_PRI_LO +: 3] <= timer_irq_priority_q;
                end
                default: RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    match_wrap_a: assert property (match_hit && !(WR && ADDR == tmr_pkg::COUNT_OFF) |=> count_q == 16'h0000)
        else $error("counter did not wrap after period match");
    match_flag_a: assert property (match_hit |=> ##1 irq_flag_q)
        else $error("flag not set after match");
    stop_hold_a: assert property (!ctrl_q.run && !WR |=> $stable(count_q))
        else $error("count moved while stopped");
    count_step_a: assert property (ps_pulse && !match_hit && !WR |=> count_q == $past(count_q) + 16'h0001)
        else $error("count step wrong");
    prescale_gate_a: assert property (!ps_pulse && !WR |=> $stable(count_q))
        else $error("count moved without prescale pulse");
    idle_halt_a: assert property (CPU_IDLE && ctrl_q.idle_stop |-> !src_tick)
        else $error("tick during idle stop");
    gate_block_a: assert property (ctrl_q.gate && !ctrl_q.cs && !ext_sync |-> !src_tick)
        else $error("gated timer counted with gate low");
    // internal clock ticks each cycle when running
    int_tick_a: assert property (ctrl_q.run && !ctrl_q.cs && !ctrl_q.gate && !stalled |-> src_tick)
        else $error("internal source missed a tick");
    sleep_run_a: assert property (ctrl_q.run && ctrl_q.cs && CPU_SLEEP && !ctrl_q.idle_stop
        && ext_rise |-> src_tick)
        else $error("external count lost in sleep");
    ext_edge_a: assert property (ctrl_q.cs && src_tick |-> ext_rise)
        else $error("external tick without edge");
    count_load_a: assert property (WR && ADDR == tmr_pkg::COUNT_OFF |=> count_q == $past(WDATA))
        else $error("count write not taken");
    gate_flag_a: assert property (ctrl_q.run && ctrl_q.gate && !ctrl_q.cs && gate_fall |=> irq_flag_q)
        else $error("flag not set after gate fall");
    // flag holds until software clears it
    flag_hold_a: assert property (irq_flag_q && !(WR && ADDR == tmr_pkg::IRQ_OFF) |=> irq_flag_q)
        else $error("flag dropped without a clear");
    irq_out_a: assert property (IRQ == $past(irq_flag_q && timer_irq_enable_q))
        else $error("request does not follow flag and enable");
    prio_out_a: assert property (IRQ_PRIORITY == $past(timer_irq_priority_q))
        else $error("priority output wrong");
    period_load_a: assert property (WR && ADDR == tmr_pkg::PERIOD_OFF |=> period_value_reg_q == $past(WDATA))
        else $error("period write not taken");
    run_off_a: assert property (!ctrl_q.run |-> !src_tick)
        else $error("tick while stopped");
    // sleep halts the instruction clock source
    sleep_stall_a: assert property (CPU_SLEEP && !ctrl_q.cs |-> !src_tick)
        else $error("internal tick during sleep");

    // Main scenarios the bench should reach
    match_seen_c: cover property (match_hit ##3 IRQ);
    gate_fall_c: cover property (ctrl_q.gate && gate_fall ##1 irq_flag_q);
    ext_count_c: cover property (ctrl_q.cs && ps_pulse);
    low_power_rc_clock_count_c: cover property (ctrl_q.ecs == tmr_pkg::ECS_LOW_POWER_RC_CLOCK && ps_pulse);
    idle_stop_c: cover property (CPU_IDLE && ctrl_q.idle_stop && ctrl_q.run);
endmodule

// >>> tmr_pkg.sv
// Package for the sixteen-bit gated timer: register map, fields, reset values
package tmr_pkg;

    // ------------------------------------------------------------
    // Register offsets (word addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] COUNT_OFF = 4'h1;
    localparam logic [3:0] PERIOD_OFF = 4'h2;
    localparam logic [3:0] IRQ_OFF = 4'h3;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int RUN_POS = 15;
    localparam int IDLE_STOP_POS = 13;
    localparam int ECS_LO = 8;
    localparam int GATE_POS = 6;
    localparam int PS_LO = 4;
    localparam int SYNC_POS = 2;
    localparam int CS_POS = 1;

    // Interrupt register field positions
    localparam int IRQ_FLAG_POS = 0;
    localparam int IRQ_EN_POS = 1;
    localparam int IRQ_PRI_LO = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [2:0] PRI_RST = 3'h4;

    // Extended clock source codes
    localparam logic [1:0] ECS_EXT_PIN = 2'h0;
    localparam logic [1:0] ECS_LOW_POWER_RC_CLOCK = 2'h2;

    // Prescale ratios 1, 8, 64, 256 expressed as terminal counts
    localparam logic [7:0] PS_TC1 = 8'h00;
    localparam logic [7:0] PS_TC8 = 8'h07;
    localparam logic [7:0] PS_TC64 = 8'h3f;
    localparam logic [7:0] PS_TC256 = 8'hff;

    // Control bits carried as one struct
    typedef struct packed {
        logic run;
        logic idle_stop;
        logic [1:0] ecs;
        logic gate;
        logic [1:0] ps;
        logic sync;
        logic cs;
    } ctrl_type;

endpackage

// >>> tmr_sync.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/100ps
module tmr_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta_q;

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    // First stage only feeds the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// >>> tmr_prescale.sv
// Prescaler: turns a stream of tick enables into one pulse per ratio
`timescale 1ns/100ps
module tmr_prescale (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic clear,
    input wire logic [1:0] sel,
    // Ticks in and out
    input wire logic tick,
    output logic pulse
);
    logic [7:0] cnt_q;
    logic [7:0] tc;

    // ------------------------------------------------------------
    // Ratio decode
    // ------------------------------------------------------------
    always_comb begin
        unique case (sel)
            2'h0: tc = tmr_pkg::PS_TC1;
            2'h1: tc = tmr_pkg::PS_TC8;
            2'h2: tc = tmr_pkg::PS_TC64;
            2'h3: tc = tmr_pkg::PS_TC256;
        endcase
    end

    // Divider; cleared when timer stops so ratio restarts cleanly
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
        end else if (clear) begin
            cnt_q <= 8'h00;
        end else if (tick) begin
            cnt_q <= (cnt_q >= tc) ? 8'h00 : cnt_q + 8'h01;
        end
    end

    assign pulse = tick && (cnt_q >= tc);
endmodule

// >>> tmr_ext_src.sv
// Partner model: external clock or gate source for the timer pins
`timescale 1ns/100ps
module tmr_ext_src (
    // Clock
    input wire logic clk,
    // Control from the bench
    input wire logic en,
    input wire logic level,
    // Pin and rising edge count
    output logic pin,
    output logic [15:0] rises
);
    logic [1:0] ph_q;
    initial begin
        ph_q = 2'h0;
        pin = 1'b0;
        rises = 16'h0000;
    end
    // slow edge bursts
    // Three cycles per level keeps edges wide enough for the synchroniser
    always @(posedge clk) begin
        ph_q <= (en && ph_q != 2'h2) ? ph_q + 2'h1 : 2'h0;
        if (!en) begin
            pin <= level;
        end else if (ph_q == 2'h2) begin
            pin <= !pin;
            rises <= rises + {15'h0000, !pin};
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench for the sixteen-bit gated timer
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic e_en = 1'b0;
    logic e_lvl = 1'b0;
    logic l_en = 1'b0;
    logic [15:0] rdata;
    logic [15:0] e_rise;
    logic [15:0] l_rise;
    logic [15:0] v;
    logic [15:0] n0;
    logic ext_pin;
    logic low_power_rc_clock_pin;
    logic irq;
    logic [2:0] irq_pri;
    int error_cnt = 0;
    int cmp_count = 0;

    // ------------------------------------------------------------
    // Design, partner models and clock
    // ------------------------------------------------------------
    tmr_top u_tmr_top (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .EXT_CLK_PIN(ext_pin), .LOW_POWER_RC_CLOCK_CLK(low_power_rc_clock_pin), .CPU_IDLE(idle),
        .CPU_SLEEP(sleep), .IRQ(irq), .IRQ_PRIORITY(irq_pri));
    tmr_ext_src u_tmr_ext_src (.clk(clk), .en(e_en), .level(e_lvl), .pin(ext_pin), .rises(e_rise));
    tmr_ext_src u_low_power_rc_clock_src (.clk(clk), .en(l_en), .level(1'b0), .pin(low_power_rc_clock_pin), .rises(l_rise));
    always #4 clk = ~clk;

    // Compare and count
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Pipeline lag makes some counts fuzzy by a cycle or two
    task automatic in_range(input string nm, input logic [15:0] x, input int lo, input int hi);
        check(nm, 16'(x >= 16'(lo) && x <= 16'(hi)), 16'h0001);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [15:0] cw(input logic r, input logic is, input logic [1:0] ecs,
        input logic g, input logic [1:0] ps, input logic sy, input logic cs);
        logic [15:0] c;
        c = 16'h0000;
        c[tmr_pkg::RUN_POS] = r;
        c[tmr_pkg::IDLE_STOP_POS] = is;
        c[tmr_pkg::ECS_LO +: 2] = ecs;
        c[tmr_pkg::GATE_POS] = g;
        c[tmr_pkg::PS_LO +: 2] = ps;
        c[tmr_pkg::SYNC_POS] = sy;
        c[tmr_pkg::CS_POS] = cs;
        return c;
    endfunction
    // Clear count, run n cycles, stop, read count into v
    task automatic run_for(input logic [15:0] c, input int n);
        wr_reg(tmr_pkg::COUNT_OFF, 16'h0000);
        wr_reg(tmr_pkg::CTRL_OFF, c);
        repeat (n) @(posedge clk);
        wr_reg(tmr_pkg::CTRL_OFF, c & 16'h7fff);
        rd_reg(tmr_pkg::COUNT_OFF, v);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_reg(tmr_pkg::CTRL_OFF, v);
        check("ctrl", v, tmr_pkg::CTRL_RST);
        rd_reg(tmr_pkg::COUNT_OFF, v);
        check("count", v, 16'h0000);
        rd_reg(tmr_pkg::PERIOD_OFF, v);
        check("period", v, tmr_pkg::PERIOD_RST);
        rd_reg(tmr_pkg::IRQ_OFF, v);
        check("irq_reg", v, 16'(tmr_pkg::PRI_RST) << tmr_pkg::IRQ_PRI_LO);
        check("irq_pri", 16'(irq_pri), 16'(tmr_pkg::PRI_RST));
        rd_reg(4'hf, v);
        check("unmapped", v, 16'h0000);
        @(posedge clk);
        #1 check("rdata_idle", rdata, 16'h0000);
    endtask
    task automatic t_prescale();
        int r[4] = '{1, 8, 64, 256};
        wr_reg(tmr_pkg::PERIOD_OFF, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            run_for(cw(1'b1, 1'b0, 2'h0, 1'b0, 2'(i), 1'b0, 1'b0), 4 * r[i]);
            in_range("ps_count", v, 3, 7);
            rd_reg(tmr_pkg::COUNT_OFF, n0);
            check("held", n0, v);
        end
    endtask
    task automatic t_match();
        int k;
        // period and interrupt set-up; count cleared so the match comes early
        wr_reg(tmr_pkg::COUNT_OFF, 16'h0000);
        wr_reg(tmr_pkg::PERIOD_OFF, 16'h0002);
        wr_reg(tmr_pkg::IRQ_OFF, 16'h0062);
        wr_reg(tmr_pkg::CTRL_OFF, cw(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0));
        for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge clk);
        check("irq", 16'(irq), 16'h0001);
        check("irq_pri", 16'(irq_pri), 16'h0006);
        wr_reg(tmr_pkg::CTRL_OFF, 16'h0000);
        rd_reg(tmr_pkg::COUNT_OFF, v);
        in_range("wrap", v, 0, 2);
        rd_reg(tmr_pkg::IRQ_OFF, v);
        check("flag", v, 16'h0063);
        wr_reg(tmr_pkg::IRQ_OFF, 16'h0062);
        repeat (3) @(posedge clk);
        check("irq_clr", 16'(irq), 16'h0000);
        // Later scenarios count well past two
        wr_reg(tmr_pkg::PERIOD_OFF, 16'hffff);
    endtask
    task automatic t_ext(input logic sy, input logic [1:0] ecs, input logic lp, input logic slp);
        sleep <= slp;
        idle <= slp;
        wr_reg(tmr_pkg::COUNT_OFF, 16'h0000);
        wr_reg(tmr_pkg::CTRL_OFF, cw(1'b1, 1'b0, ecs, 1'b0, 2'h0, sy, 1'b1));
        rd_reg(tmr_pkg::CTRL_OFF, v);
        check("ctrl_rb", v, cw(1'b1, 1'b0, ecs, 1'b0, 2'h0, sy, 1'b1));
        n0 = lp ? l_rise : e_rise;
        l_en <= lp;
        e_en <= !lp;
        repeat (60) @(posedge clk);
        l_en <= 1'b0;
        e_en <= 1'b0;
        repeat (10) @(posedge clk);
        wr_reg(tmr_pkg::CTRL_OFF, 16'h0000);
        rd_reg(tmr_pkg::COUNT_OFF, v);
        check("ext_count", v, (lp ? l_rise : e_rise) - n0);
        sleep <= 1'b0;
        idle <= 1'b0;
    endtask
    task automatic t_gate();
        wr_reg(tmr_pkg::IRQ_OFF, 16'h0002);
        wr_reg(tmr_pkg::COUNT_OFF, 16'h0000);
        wr_reg(tmr_pkg::CTRL_OFF, cw(1'b1, 1'b0, 2'h0, 1'b1, 2'h0, 1'b0, 1'b0));
        e_lvl <= 1'b1;
        repeat (20) @(posedge clk);
        e_lvl <= 1'b0;
        repeat (8) @(posedge clk);
        rd_reg(tmr_pkg::IRQ_OFF, v);
        check("gate_flag", v, 16'h0003);
        wr_reg(tmr_pkg::CTRL_OFF, 16'h0000);
        rd_reg(tmr_pkg::COUNT_OFF, v);
        in_range("gate_count", v, 18, 23);
    endtask
    task automatic t_idle();
        idle <= 1'b1;
        run_for(cw(1'b1, 1'b1, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0), 30);
        check("idle_stop", v, 16'h0000);
        run_for(cw(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0), 30);
        in_range("idle_run", v, 28, 34);
        idle <= 1'b0;
        sleep <= 1'b1;
        run_for(cw(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0), 30);
        check("sleep_int", v, 16'h0000);
        sleep <= 1'b0;
    endtask
    task automatic t_rst();
        wr_reg(tmr_pkg::CTRL_OFF, cw(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0));
        repeat (5) @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Whole run needs under 5000 cycles
    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_prescale();
        t_match();
        t_ext(1'b0, 2'h0, 1'b0, 1'b0);
        t_ext(1'b1, 2'h0, 1'b0, 1'b1);
        t_ext(1'b0, tmr_pkg::ECS_LOW_POWER_RC_CLOCK, 1'b1, 1'b0);
        t_gate();
        t_idle();
        t_rst();
        conclude();
    end
endmodule
